// ==== rtl/sccd_top.sv ====
// Serial configuration command decoder: 8N1 receiver, frame and
// escape decoder, register map and reply transmitter in one module.
// Assumes serial_rx and the status inputs are synchronous to clk.
`timescale 1ns/1ps
module sccd_top #(
  parameter logic [31:0] FACTORY_SERIAL = 32'h1234_5678 // Arbitrary value
) (
  input wire logic clk, // 20 MHz clock
  input wire logic resetn, // Sync reset, active low
  input wire logic serial_rx, // Command data from host
  output logic serial_tx, // Replies to host
  input wire logic command_select_pin_n, // Command select, active low
  input wire logic [7:0] status_line_in, // Status line state
  input wire logic [7:0] packet_rssi_in, // Packet signal strength
  input wire logic [7:0] ambient_rssi_in, // Ambient signal strength
  input wire logic [7:0] output_line_in, // Output line status
  input wire logic [7:0] security_in, // Security status
  input wire logic [7:0] join_in, // Join status
  output logic rf_data_hold, // Hold received radio data
  output logic [7:0] transmit_power, // Volatile power setting
  output logic [7:0] hop_sequence_select, // Volatile hop table
  output logic command_strobe, // Command register written
  output logic [7:0] command_value // Last command value
);

  typedef struct packed {
    sccd_pkg::sccd_state_t st;
    logic [7:0] len;
    logic [7:0] ecnt;
    logic [5:0] ndec;
    logic [1:0] esc;
    logic [7:0] b0;
    logic nack;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_ok;
    logic [7:0] rx_byte;
    logic tx_busy;
    logic tx_out;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic [2:0][7:0] rep;
    logic [1:0] rep_n;
    logic [1:0] rep_i;
    logic hold;
    logic cmd_stb;
    logic [7:0] cmd_val;
    logic [255:0][7:0] regs;
  } sccd_q_t;

  sccd_q_t q_q;
  sccd_q_t q_d;
  logic [7:0] rb;
  logic [7:0] dec;
  logic [7:0] waddr;
  logic [7:0] b0_new;
  logic [7:0] ra;
  logic [15:0] bc;
  logic [5:0] nd_new;
  logic is_esc;
  logic inv;
  logic last;
  logic nack_new;

  // Read mux: live status inputs, fixed serial number, else storage
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    case (a)
      sccd_pkg::A_SLS: return status_line_in;
      sccd_pkg::A_PACKET_SIGNAL_STRENGTH: return packet_rssi_in;
      sccd_pkg::A_AMBIENT_SIGNAL_STRENGTH: return ambient_rssi_in;
      sccd_pkg::A_LSTAT: return output_line_in;
      sccd_pkg::A_SECST: return security_in;
      sccd_pkg::A_JOIN: return join_in;
      8'h34: return FACTORY_SERIAL[31:24];
      8'h35: return FACTORY_SERIAL[23:16];
      8'h36: return FACTORY_SERIAL[15:8];
      8'h37: return FACTORY_SERIAL[7:0];
      default: return q_q.regs[a];
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    q_d = q_q;
    rb = q_q.rx_byte;
    bc = sccd_pkg::bit_cyc(q_q.regs[sccd_pkg::A_RATE]);
    is_esc = (rb == sccd_pkg::ESC);
    // Lone escape flips; a pair cancels except on the top range
    inv = (q_q.esc == 2'd1) || (q_q.esc == 2'd2 && rb >= sccd_pkg::TOP);
    dec = inv ? (rb ^ sccd_pkg::MSB) : rb;
    last = (8'(q_q.ecnt + 8'd1) == q_q.len);
    waddr = 8'(q_q.b0 + 8'(q_q.ndec - 6'd1));
    nd_new = q_q.ndec;
    b0_new = q_q.b0;
    nack_new = q_q.nack;
    if (!is_esc) begin
      nd_new = (q_q.ndec == 6'h3f) ? q_q.ndec : 6'(q_q.ndec + 6'd1);
      if (q_q.ndec == 6'd0) begin
        b0_new = dec;
      end else if (!sccd_pkg::writable(waddr)) begin
        nack_new = 1'b1;
      end
    end
    ra = b0_new ^ sccd_pkg::MSB;
    q_d.rx_ok = 1'b0;
    q_d.cmd_stb = 1'b0;
    // Hold only while the select pin is low and the setting is set
    q_d.hold = !command_select_pin_n && (q_q.regs[sccd_pkg::A_HOLD] != 8'h00);

    // Receiver: sample mid-bit, bit 0 start, 1..8 data, 9 stop
    if (!q_q.rx_busy) begin
      if (!serial_rx) begin
        q_d.rx_busy = 1'b1;
        q_d.rx_cnt = bc >> 1;
        q_d.rx_bit = 4'd0;
      end
    end else if (q_q.rx_cnt != 16'd0) begin
      q_d.rx_cnt = q_q.rx_cnt - 16'd1;
    end else begin
      q_d.rx_cnt = bc - 16'd1;
      q_d.rx_bit = q_q.rx_bit + 4'd1;
      if (q_q.rx_bit == 4'd0 && serial_rx) begin
        q_d.rx_busy = 1'b0; // Glitch, not a start bit
      end else if (q_q.rx_bit == 4'd9) begin
        q_d.rx_busy = 1'b0;
        q_d.rx_ok = serial_rx; // Bad stop bit drops the byte
        q_d.rx_byte = q_q.rx_sh;
      end else if (q_q.rx_bit != 4'd0) begin
        q_d.rx_sh = {serial_rx, q_q.rx_sh[7:1]};
      end
    end

    // Frame decoder; bytes arriving while a reply goes out are dropped
    if (q_q.rx_ok && q_q.st != sccd_pkg::ST_REPLY) begin
      if (rb == sccd_pkg::HDR) begin
        q_d.st = sccd_pkg::ST_LEN;
      end else begin
        unique case (q_q.st)
          sccd_pkg::ST_IDLE: begin
            q_d.st = sccd_pkg::ST_IDLE;
          end
          sccd_pkg::ST_LEN: begin
            q_d.len = rb;
            q_d.ecnt = 8'd0;
            q_d.ndec = 6'd0;
            q_d.esc = 2'd0;
            q_d.nack = 1'b0;
            q_d.st = (rb == 8'h00) ? sccd_pkg::ST_IDLE : sccd_pkg::ST_BODY;
          end
          sccd_pkg::ST_BODY: begin
            q_d.ecnt = 8'(q_q.ecnt + 8'd1);
            q_d.ndec = nd_new;
            q_d.b0 = b0_new;
            q_d.nack = nack_new;
            if (is_esc) begin
              q_d.esc = (q_q.esc == 2'd1) ? 2'd2 : 2'd1;
            end else begin
              q_d.esc = 2'd0;
              // Extra values land on successive registers
              if (q_q.ndec != 6'd0 && sccd_pkg::writable(waddr)) begin
                q_d.regs[waddr] = dec;
                if (waddr == sccd_pkg::A_CMD) begin
                  q_d.cmd_stb = 1'b1;
                  q_d.cmd_val = dec;
                end
              end
            end
            if (last) begin
              q_d.rep_i = 2'd0;
              q_d.st = sccd_pkg::ST_REPLY;
              if (nd_new == 6'd0) begin
                q_d.st = sccd_pkg::ST_IDLE;
              end else if (nd_new == 6'd1 && sccd_pkg::readable(ra)) begin
                q_d.rep[0] = sccd_pkg::ACK;
                q_d.rep[1] = ra;
                q_d.rep[2] = rd_val(ra);
                q_d.rep_n = 2'd3;
              end else begin
                q_d.rep[0] = (nd_new == 6'd1 || nack_new) ? sccd_pkg::NACK : sccd_pkg::ACK;
                q_d.rep_n = 2'd1;
              end
            end
          end
          sccd_pkg::ST_REPLY: begin
            q_d.st = sccd_pkg::ST_REPLY;
          end
        endcase
      end
    end

    // Reply transmitter, one byte after another
    if (q_q.st == sccd_pkg::ST_REPLY && !q_q.tx_busy) begin
      if (q_q.rep_i == q_q.rep_n) begin
        q_d.st = sccd_pkg::ST_IDLE;
        q_d.rep_n = 2'd0;
      end else begin
        q_d.tx_busy = 1'b1;
        q_d.tx_out = 1'b0;
        q_d.tx_sh = {1'b1, q_q.rep[q_q.rep_i]};
        q_d.tx_cnt = bc - 16'd1;
        q_d.tx_bit = 4'd0;
        q_d.rep_i = q_q.rep_i + 2'd1;
      end
    end else if (q_q.tx_busy) begin
      if (q_q.tx_cnt != 16'd0) begin
        q_d.tx_cnt = q_q.tx_cnt - 16'd1;
      end else if (q_q.tx_bit == 4'd9) begin
        q_d.tx_busy = 1'b0; // Stop bit done
      end else begin
        q_d.tx_out = q_q.tx_sh[0];
        q_d.tx_sh = {1'b0, q_q.tx_sh[8:1]};
        q_d.tx_bit = q_q.tx_bit + 4'd1;
        q_d.tx_cnt = bc - 16'd1;
      end
    end

    // Reset loads the default map; serial line idles high
    if (!resetn) begin
      q_d = '0;
      q_d.st = sccd_pkg::ST_IDLE;
      q_d.tx_out = 1'b1;
      for (int i = 0; i < 256; i++) begin
        q_d.regs[i] = sccd_pkg::rst_val(8'(i));
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    q_q <= q_d;
  end

  // Outputs straight from flops
  assign serial_tx = q_q.tx_out;
  assign rf_data_hold = q_q.hold;
  assign transmit_power = q_q.regs[sccd_pkg::A_TRANSMIT_POWER];
  assign hop_sequence_select = q_q.regs[sccd_pkg::A_HOP];
  assign command_strobe = q_q.cmd_stb;
  assign command_value = q_q.cmd_val;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic body_data;
  assign body_data = q_q.rx_ok && q_q.st == sccd_pkg::ST_BODY && rb != sccd_pkg::HDR && !is_esc;

  sequence s_frame_end;
    q_q.rx_ok && q_q.st == sccd_pkg::ST_BODY && rb != sccd_pkg::HDR && last;
  endsequence

  sequence s_tx_start;
    $rose(q_q.tx_busy);
  endsequence

  a_literal_pass: assert property (body_data && q_q.esc == 2'd0 |-> dec == rb)
    else $error("literal byte altered");
  a_escape_flip: assert property (body_data && q_q.esc == 2'd1 |-> dec == {~rb[7], rb[6:0]})
    else $error("escape did not flip bit 7");
  a_double_cancel: assert property (body_data && q_q.esc == 2'd2 |->
    dec == ((rb >= sccd_pkg::TOP) ? (rb ^ sccd_pkg::MSB) : rb))
    else $error("double escape wrong");
  a_read_answer: assert property (s_frame_end and (nd_new == 6'd1 && sccd_pkg::readable(ra)) |=>
    q_q.rep_n == 2'd3 && q_q.rep[0] == sccd_pkg::ACK && q_q.rep[1] == $past(ra))
    else $error("read reply wrong");
  a_read_nack: assert property (s_frame_end and (nd_new == 6'd1 && !sccd_pkg::readable(ra)) |=>
    q_q.rep_n == 2'd1 && q_q.rep[0] == sccd_pkg::NACK)
    else $error("bad read not refused");
  a_write_answer: assert property (s_frame_end and (nd_new > 6'd1) |=> q_q.st == sccd_pkg::ST_REPLY &&
    q_q.rep_n == 2'd1 && q_q.rep[0] == ($past(nack_new) ? sccd_pkg::NACK : sccd_pkg::ACK))
    else $error("write reply wrong");
  a_serial_ro: assert property (body_data && q_q.ndec != 6'd0 &&
    waddr >= sccd_pkg::A_SN_LO && waddr <= sccd_pkg::A_SN_HI |=> q_q.nack)
    else $error("serial number write accepted");
  a_header_restart: assert property (q_q.rx_ok && rb == sccd_pkg::HDR && q_q.st != sccd_pkg::ST_REPLY |=>
    q_q.st == sccd_pkg::ST_LEN && q_q.rep_n == 2'd0)
    else $error("header did not restart frame");
  // First edge after release still shows the reset value, so skip it
  a_hold_track: assert property ($past(resetn) |-> rf_data_hold ==
    $past(!command_select_pin_n && q_q.regs[sccd_pkg::A_HOLD] != 8'h00))
    else $error("hold output wrong");
  a_reset_defaults: assert property ($rose(resetn) |-> q_q.regs[sccd_pkg::A_CSTH] == sccd_pkg::CSTH_RST &&
    q_q.regs[sccd_pkg::A_HOLD] == 8'h01 && q_q.regs[sccd_pkg::A_HOLD_NV] == 8'h01)
    else $error("reset defaults wrong");
  a_tx_start_bit: assert property (s_tx_start |-> (!serial_tx) [*8])
    else $error("start bit too short");

  // ----------------------------------------
  // Link and register map checks
  // ----------------------------------------
  // Line rests high whenever no reply byte is on the way
  a_tx_idle_high: assert property (!q_q.tx_busy |-> serial_tx)
    else $error("transmit line not idle high");

  // A bit never changes before its period has run out
  a_tx_bit_hold: assert property (q_q.tx_busy && q_q.tx_cnt != 16'd0 |=> $stable(serial_tx))
    else $error("transmit bit cut short");

  // A start bit that is gone at mid-bit was only a glitch
  a_rx_glitch_drop: assert property (q_q.rx_busy && q_q.rx_bit == 4'd0 &&
    q_q.rx_cnt == 16'd0 && serial_rx |=> !q_q.rx_busy)
    else $error("glitch taken as start bit");

  // A low stop sample must never hand a byte on
  a_rx_stop_check: assert property (q_q.rx_busy && q_q.rx_bit == 4'd9 &&
    q_q.rx_cnt == 16'd0 && !serial_rx |=> !q_q.rx_ok)
    else $error("byte with bad stop bit accepted");

  // Escape bytes are dropped, not counted as decoded bytes
  a_escape_dropped: assert property (q_q.rx_ok && q_q.st == sccd_pkg::ST_BODY && is_esc |=>
    q_q.ndec == $past(q_q.ndec))
    else $error("escape byte counted as data");

  // Writable targets take the decoded value on the next edge
  a_write_lands: assert property (body_data && q_q.ndec != 6'd0 && sccd_pkg::writable(waddr) |=>
    q_q.regs[$past(waddr)] == $past(dec))
    else $error("write did not land");

  // Read-only or unknown targets mark the frame for refusal
  a_bad_target_nack: assert property (body_data && q_q.ndec != 6'd0 && !sccd_pkg::writable(waddr) |=>
    q_q.nack)
    else $error("bad write target not flagged");

  // Command register write gives one strobe and keeps the value
  a_cmd_strobe: assert property (body_data && q_q.ndec != 6'd0 && waddr == sccd_pkg::A_CMD |=>
    command_strobe && command_value == $past(dec))
    else $error("command write not strobed");

  // Strobe is a single-cycle pulse
  a_cmd_pulse: assert property (command_strobe |=> !command_strobe)
    else $error("command strobe too long");

  // Empty frame is dropped without a reply
  a_len_zero: assert property (q_q.rx_ok && q_q.st == sccd_pkg::ST_LEN && rb == 8'h00 |=>
    q_q.st == sccd_pkg::ST_IDLE)
    else $error("empty frame not dropped");

  // Bytes heard while replying leave the frame state alone
  a_reply_deaf: assert property (q_q.rx_ok && q_q.st == sccd_pkg::ST_REPLY |=>
    q_q.len == $past(q_q.len) && q_q.ecnt == $past(q_q.ecnt))
    else $error("byte taken during reply");
endmodule

// ==== rtl/sccd_pkg.sv ====
// Constants, register map and decode helpers for the serial
// configuration command decoder.
// Assumes one 20 MHz clock and a host on an 8N1 serial link.
package sccd_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_DEF = 9600;
  localparam logic [7:0] HDR = 8'hff;
  localparam logic [7:0] ESC = 8'hfe;
  localparam logic [7:0] TOP = 8'hf0;
  localparam logic [7:0] MSB = 8'h80;
  localparam logic [7:0] ACK = 8'h06;
  localparam logic [7:0] NACK = 8'h15;
  localparam logic [7:0] A_HOP = 8'h4b;
  localparam logic [7:0] A_TRANSMIT_POWER = 8'h4d;
  localparam logic [7:0] A_RATE = 8'h4e;
  localparam logic [7:0] A_HOLD = 8'h6e;
  localparam logic [7:0] A_HOLD_NV = 8'h23;
  localparam logic [7:0] A_SLS = 8'h7a;
  localparam logic [7:0] A_PACKET_SIGNAL_STRENGTH = 8'h7b;
  localparam logic [7:0] A_AMBIENT_SIGNAL_STRENGTH = 8'h7c;
  localparam logic [7:0] A_LSTAT = 8'hc6;
  localparam logic [7:0] A_CMD = 8'hc7;
  localparam logic [7:0] A_SECST = 8'hc9;
  localparam logic [7:0] A_JOIN = 8'hca;
  localparam logic [7:0] A_SN_LO = 8'h34;
  localparam logic [7:0] A_SN_HI = 8'h37;
  localparam logic [7:0] A_CSTH = 8'h3f;
  localparam logic [7:0] CSTH_RST = 8'ha4;
  localparam logic [7:0] NV_LO_OFS = 8'h4b;
  localparam logic [7:0] NV_LO_TOP = 8'h26;
  localparam logic [7:0] NV_HI_LO = 8'h80;
  localparam logic [7:0] NV_HI_TOP = 8'h84;
  localparam logic [7:0] NV_HI_OFS = 8'h50;
  localparam int VOL_N = 41;
  // crc_error_count, hop_sequence_select .. wake_acknowledge, user ids,
  // masks, dest serial, remote ctrl .. auto reply, exception flags/masks
  localparam logic [7:0] VOL_ADDR [VOL_N] = '{
    8'h40, 8'h4b, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h52, 8'h53, 8'h54, 8'h56,
    8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61,
    8'h62, 8'h63, 8'h64, 8'h65, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6d, 8'h6e,
    8'h6f, 8'h70, 8'h71, 8'hcd, 8'hce, 8'hcf, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4};
  localparam logic [7:0] VOL_RST [VOL_N] = '{
    8'h00, 8'hff, 8'h03, 8'h01, 8'h0f, 8'h10, 8'h02, 8'h01, 8'h40, 8'h02,
    8'h01, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h01,
    8'hff, 8'h02, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LEN = 4'b0010,
    ST_BODY = 4'b0100,
    ST_REPLY = 4'b1000
  } sccd_state_t;

  // Default of a volatile entry, zero when not in the table
  function automatic logic [7:0] vol_rst(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < VOL_N; i++) begin
      if (VOL_ADDR[i] == a) begin
        v = VOL_RST[i];
      end
    end
    return v;
  endfunction

  function automatic logic vol_rw(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < VOL_N; i++) begin
      if (VOL_ADDR[i] == a) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Non-volatile copies sit at fixed distances below the volatile ones
  function automatic logic nv_rw(input logic [7:0] a);
    return (a <= NV_LO_TOP && vol_rw(8'(a + NV_LO_OFS))) ||
           (a >= NV_HI_LO && a <= NV_HI_TOP) || a == A_CSTH;
  endfunction

  function automatic logic writable(input logic [7:0] a);
    return vol_rw(a) || nv_rw(a) || a == A_CMD;
  endfunction

  function automatic logic readable(input logic [7:0] a);
    return vol_rw(a) || nv_rw(a) || (a >= A_SN_LO && a <= A_SN_HI) ||
           a == A_SLS || a == A_PACKET_SIGNAL_STRENGTH || a == A_AMBIENT_SIGNAL_STRENGTH || a == A_LSTAT ||
           a == A_SECST || a == A_JOIN;
  endfunction

  function automatic logic [7:0] rst_val(input logic [7:0] a);
    if (vol_rw(a)) return vol_rst(a);
    if (a <= NV_LO_TOP) return vol_rst(8'(a + NV_LO_OFS));
    if (a >= NV_HI_LO && a <= NV_HI_TOP) return vol_rst(8'(a + NV_HI_OFS));
    if (a == A_CSTH) return CSTH_RST;
    return 8'h00;
  endfunction

  // Clocks per bit for each rate code; unknown codes fall back to default
  function automatic logic [15:0] bit_cyc(input logic [7:0] sel);
    case (sel)
      8'h02: return 16'(CLK_HZ / 19200);
      8'h03: return 16'(CLK_HZ / 38400);
      8'h04: return 16'(CLK_HZ / 57600);
      8'h05: return 16'(CLK_HZ / 115200);
      default: return 16'(CLK_HZ / BAUD_DEF);
    endcase
  endfunction
endpackage

// ==== tb/sccd_host_model.sv ====
// Host side of the serial command link: sends encoded frames and
// collects the reply bytes. Assumes the bench supplies clk only.
`timescale 1ns/1ps
module sccd_host_model (
  input wire logic clk, // Bench clock
  output logic tx_line, // Drives the device receive line
  input wire logic rx_line // Watches the device transmit line
);
  // --------------------------------------------------------------
  // Link timing and byte tasks
  // --------------------------------------------------------------
  int bit_cyc = 2083; // Default rate, 20 MHz over 9600
  initial tx_line = 1'b1;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Start, eight bits LSB first, stop; line rests high
  task automatic send(input logic [7:0] b, input bit last);
    tx_line <= 1'b0;
    wait_cyc(bit_cyc);
    for (int i = 0; i < 8; i++) begin
      tx_line <= b[i];
      wait_cyc(bit_cyc);
    end
    tx_line <= 1'b1;
    // Last stop bit overlaps the reply, so do not sit on it
    if (!last) begin
      wait_cyc(bit_cyc);
    end
  endtask

  // Bounded wait for a start bit, then mid-bit sampling
  task automatic recv(output logic [7:0] b, output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    b = 8'h00;
    while (rx_line !== 1'b0 && n < 20 * bit_cyc) begin
      @(posedge clk);
      n++;
    end
    if (rx_line !== 1'b0) begin
      return;
    end
    wait_cyc(bit_cyc / 2);
    for (int i = 0; i < 8; i++) begin
      wait_cyc(bit_cyc);
      b[i] = rx_line;
    end
    wait_cyc(bit_cyc);
    ok = (rx_line === 1'b1); // Stop bit high
  endtask

  // Frames come pre-encoded: header, length, field, no reserved literal
  // bytes, 1 to 32 raw bytes
  task automatic frame(input logic [7:0] q[$], input int nb, output logic [7:0] got[$]);
    logic [7:0] b;
    bit ok;
    got = {};
    foreach (q[i]) begin
      send(q[i], i == q.size() - 1);
    end
    if (nb != 0) begin
      bit_cyc = nb;
    end
    do begin
      recv(b, ok);
      if (ok) begin
        got.push_back(b);
      end
    end while (ok);
  endtask
endmodule

// ==== tb/serial_config_command_decoder_tb.sv ====
// Self-checking bench for the serial configuration command decoder.
// Assumes sccd_top and the host model; one 20 MHz clock.
`timescale 1ns/1ps
module serial_config_command_decoder_tb;
  // --------------------------------------------------------------
  // Stimulus signals and instances
  // --------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pin_n = 1'b0;
  logic [7:0] rssi = 8'h5c;
  logic [7:0] join_st = 8'h3c;
  logic serial_rx;
  logic serial_tx;
  logic rf_data_hold;
  logic [7:0] tx_pwr;
  logic [7:0] hop;
  logic command_strobe;
  logic [7:0] command_value;
  int mismatches = 0;
  int num_checks = 0;
  int strobes = 0;
  int tnum = 0;

  always #25 clk = ~clk;

  sccd_top dut (.clk(clk), .resetn(resetn), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .command_select_pin_n(pin_n), .status_line_in(8'h00), .packet_rssi_in(rssi),
    .ambient_rssi_in(8'h11), .output_line_in(8'h22), .security_in(8'h33), .join_in(join_st),
    .rf_data_hold(rf_data_hold), .transmit_power(tx_pwr), .hop_sequence_select(hop),
    .command_strobe(command_strobe), .command_value(command_value));

  sccd_host_model host (.clk(clk), .tx_line(serial_rx), .rx_line(serial_tx));

  // Count command pulses; each write must give exactly one
  always @(posedge clk) begin
    if (command_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end

  // --------------------------------------------------------------
  // Checking and transfer tasks
  // --------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One frame out, whole reply back, byte-for-byte compare
  task automatic xfer(input logic [7:0] tx[$], input logic [7:0] rx[$], input int nb = 0);
    logic [7:0] got[$];
    host.frame(tx, nb, got);
    check("reply_len", 8'(got.size()), 8'(rx.size()));
    foreach (rx[i]) begin
      check("reply_byte", got[i], rx[i]);
    end
    tnum++;
    $display("test %0d done", tnum);
  endtask

  // Hang guard sized for one slow frame and the fast ones after it
  initial begin
    #30_000_000;
    mismatches++;
    wrap_up();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("serial_tx", {7'h00, serial_tx}, 8'h01);
    check("transmit_power", tx_pwr, 8'h03);
    check("hop_select", hop, 8'hff);
    check("command_value", command_value, 8'h00);
    check("data_hold", {7'h00, rf_data_hold}, 8'h01);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("data_hold", {7'h00, rf_data_hold}, 8'h00);
    pin_n <= 1'b0;
    // Move to the fastest rate; the reply already uses it
    xfer('{8'hff, 8'h02, 8'h4e, 8'h05}, '{8'h06}, 20_000_000 / 115200);
    xfer('{8'hff, 8'h01, 8'hcd}, '{8'h06, 8'h4d, 8'h03});
    xfer('{8'hff, 8'h02, 8'hfe, 8'h4d}, '{8'h06, 8'h4d, 8'h03});
    xfer('{8'hff, 8'h03, 8'hfe, 8'hfe, 8'h53}, '{8'h06, 8'hd3, 8'h01});
    xfer('{8'hff, 8'h04, 8'h4d, 8'hfe, 8'hfe, 8'h75}, '{8'h06});
    check("transmit_power", tx_pwr, 8'h75);
    xfer('{8'hff, 8'h03, 8'h4b, 8'hfe, 8'h02}, '{8'h06});
    check("hop_select", hop, 8'h82);
    xfer('{8'hff, 8'h03, 8'hfe, 8'h47, 8'h5a}, '{8'h06});
    check("command_value", command_value, 8'h5a);
    check("command_pulses", 8'(strobes), 8'h01);
    xfer('{8'hff, 8'h02, 8'h7b, 8'h01}, '{8'h15});
    xfer('{8'hff, 8'h01, 8'h47}, '{8'h15});
    xfer('{8'hff, 8'h02, 8'hfe, 8'h7b}, '{8'h06, 8'h7b, 8'h5c});
    xfer('{8'hff, 8'h01, 8'h4a}, '{8'h06, 8'hca, 8'h3c});
    xfer('{8'hff, 8'h02, 8'hfe, 8'h3f}, '{8'h06, 8'h3f, 8'ha4});
    xfer('{8'hff, 8'h02, 8'hfe, 8'h34}, '{8'h06, 8'h34, 8'h12});
    xfer('{8'hff, 8'h02, 8'h34, 8'h00}, '{8'h15});
    // Abandoned write, then a read of the untouched register
    xfer('{8'hff, 8'h03, 8'h4d, 8'hff, 8'h01, 8'hcd}, '{8'h06, 8'h4d, 8'h75});
    xfer('{8'hff, 8'h02, 8'h40, 8'hef}, '{8'h06});
    xfer('{8'hff, 8'h01, 8'hc0}, '{8'h06, 8'h40, 8'hef});
    xfer('{8'hff, 8'h02, 8'h6e, 8'h00}, '{8'h06});
    repeat (3) @(posedge clk);
    check("data_hold", {7'h00, rf_data_hold}, 8'h00);
    wrap_up();
  end
endmodule
